/* common/sdsi_pkg.sv */
/*
  Package of the switch drop statistics and interrupt register bank: register
  indices, field positions, reset values, drop reason codes and the carrier
  types shared by the register bank and its surroundings.
  Assumes a 32-bit APB in which register index n sits at byte address 4*n.
*/
package sdsi_pkg;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam int unsigned         ADDR_W        = 16;
  localparam logic [ADDR_W-3:0]   IDX_CNT_PORT0 = 14'h1C16;
  localparam logic [ADDR_W-3:0]   IDX_CNT_PORT1 = 14'h1C17;
  localparam logic [ADDR_W-3:0]   IDX_CNT_PORT2 = 14'h1C18;
  localparam logic [ADDR_W-3:0]   IDX_IRQ_MASK  = 14'h1C20;
  localparam logic [ADDR_W-3:0]   IDX_IRQ_PEND  = 14'h1C21;
  localparam logic [ADDR_W-3:0]   IDX_EVT_STAT  = 14'h1C30;
  localparam logic [ADDR_W-3:0]   IDX_EVT_CLR   = 14'h1C31;
  localparam logic [ADDR_W-3:0]   IDX_EVT_EN    = 14'h1C32;
  localparam int unsigned         IDX_LSB       = 2;

  // ---------------------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned  NUM_PORTS     = 3;
  localparam int unsigned  MASK_BIT      = 0;
  localparam logic         MASK_RST      = 1'b1;
  localparam int unsigned  PEND_A_VALID  = 0;
  localparam int unsigned  PEND_A_PORT   = 1;
  localparam int unsigned  PEND_A_REASON = 3;
  localparam int unsigned  PEND_B_VALID  = 7;
  localparam int unsigned  PEND_B_PORT   = 8;
  localparam int unsigned  PEND_B_REASON = 10;
  localparam logic [31:0]  CNT_RST       = 32'h0000_0000;
  localparam int unsigned  EVT_W         = 5;
  localparam int unsigned  EVT_RECORD    = 3;
  localparam int unsigned  EVT_LOST      = 4;
  localparam logic [EVT_W-1:0] EVT_RST   = 5'h00;

  // ---------------------------------------------------------------------------
  // Drop reason codes and port codes
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    SDSI_RSN_BCAST_LEVEL = 4'h0,
    SDSI_RSN_RED         = 4'h1,
    SDSI_RSN_NO_BUFFER   = 4'h2,
    SDSI_RSN_NO_DESC     = 4'h3,
    SDSI_RSN_NO_DEST     = 4'h4,
    SDSI_RSN_RX_ERROR    = 4'h5,
    SDSI_RSN_DROP_LEVEL  = 4'h6,
    SDSI_RSN_YELLOW      = 4'h9
  } sdsi_reason_t;

  localparam logic [1:0] PORT_CODE_RSVD = 2'h3;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] reason;
    logic [1:0] port;
  } sdsi_drop_info_t;

  typedef struct packed {
    logic            valid;
    sdsi_drop_info_t info;
  } sdsi_drop_rec_t;

endpackage : sdsi_pkg

/* rtl/sdsi_regs.sv */
/*
  Drop statistics and interrupt register bank of the switch buffer manager:
  three saturating clear-on-read ingress rate drop counters, the interrupt mask,
  the double-buffered drop status register and a sticky event status block,
  all reached over APB with no wait states.
  Assumes drop pulses and drop records arrive from logic on pclk.
*/
// Implementation choice: register access over APB.
`timescale 1ns/1ps

module sdsi_regs #(
  parameter int unsigned CNT_W = 32
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [sdsi_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [sdsi_pkg::NUM_PORTS-1:0] rate_drop,
  input  wire sdsi_pkg::sdsi_drop_rec_t       drop_evt,
  output logic                               irq
);
  import sdsi_pkg::*;

  localparam logic [CNT_W-1:0] CNT_MAX  = {CNT_W{1'b1}};
  localparam logic [CNT_W-1:0] CNT_ZERO = CNT_RST[CNT_W-1:0];
  localparam logic [CNT_W-1:0] CNT_ONE  = {{(CNT_W-1){1'b0}}, 1'b1};

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  // Read data is captured in the setup cycle so that prdata comes from flops;
  // the clear-on-read side effects are applied at the access edge instead.
  logic [ADDR_W-3:0] idx;
  logic              setup;
  logic              access;
  logic              hit_cnt0, hit_cnt1, hit_cnt2, hit_mask, hit_pend;
  logic              hit_stat, hit_clr, hit_en, mapped, bad;

  assign idx      = paddr[ADDR_W-1:IDX_LSB];
  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign hit_cnt0 = (idx == IDX_CNT_PORT0);
  assign hit_cnt1 = (idx == IDX_CNT_PORT1);
  assign hit_cnt2 = (idx == IDX_CNT_PORT2);
  assign hit_mask = (idx == IDX_IRQ_MASK);
  assign hit_pend = (idx == IDX_IRQ_PEND);
  assign hit_stat = (idx == IDX_EVT_STAT);
  assign hit_clr  = (idx == IDX_EVT_CLR);
  assign hit_en   = (idx == IDX_EVT_EN);
  assign mapped   = hit_cnt0 | hit_cnt1 | hit_cnt2 | hit_mask | hit_pend
                  | hit_stat | hit_clr | hit_en;
  // Unmapped indices and a read of the write-only clear register are refused.
  assign bad      = !mapped || (hit_clr && !pwrite);

  assign pready   = 1'b1;
  assign pslverr  = access && bad;

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic [CNT_W-1:0]     cnt_r   [NUM_PORTS];
  logic [CNT_W-1:0]     cnt_nxt [NUM_PORTS];
  logic [CNT_W-1:0]     snap_r,  snap_nxt;
  logic                 mask_r,  mask_nxt;
  sdsi_drop_rec_t       rec_a_r, rec_a_nxt;
  sdsi_drop_rec_t       rec_b_r, rec_b_nxt;
  logic [EVT_W-1:0]     stat_r,  stat_nxt;
  logic [EVT_W-1:0]     en_r,    en_nxt;
  logic [31:0]          rdata_r, rdata_nxt;
  logic                 rd_cnt   [NUM_PORTS];
  logic                 rd_pend;
  logic                 clr_a, clr_b;
  logic                 rec_lost;

  // ---------------------------------------------------------------------------
  // Read data capture
  // ---------------------------------------------------------------------------
  always_comb begin
    rdata_nxt = rdata_r;
    snap_nxt  = snap_r;
    if (setup) begin
      rdata_nxt = 32'h0000_0000;
      if (!pwrite) begin
        if (hit_cnt0) begin
          rdata_nxt[CNT_W-1:0] = cnt_r[0];
          snap_nxt             = cnt_r[0];
        end
        if (hit_cnt1) begin
          rdata_nxt[CNT_W-1:0] = cnt_r[1];
          snap_nxt             = cnt_r[1];
        end
        if (hit_cnt2) begin
          rdata_nxt[CNT_W-1:0] = cnt_r[2];
          snap_nxt             = cnt_r[2];
        end
        if (hit_mask) begin
          rdata_nxt[MASK_BIT] = mask_r;
        end
        if (hit_pend) begin
          rdata_nxt[PEND_A_VALID]                   = rec_a_r.valid;
          rdata_nxt[PEND_A_PORT+:2]                 = rec_a_r.info.port;
          rdata_nxt[PEND_A_REASON+:4]               = rec_a_r.info.reason;
          rdata_nxt[PEND_B_VALID]                   = rec_b_r.valid;
          rdata_nxt[PEND_B_PORT+:2]                 = rec_b_r.info.port;
          rdata_nxt[PEND_B_REASON+:4]               = rec_b_r.info.reason;
        end
        if (hit_stat) begin
          rdata_nxt[EVT_W-1:0] = stat_r;
        end
        if (hit_en) begin
          rdata_nxt[EVT_W-1:0] = en_r;
        end
      end
    end
  end

  assign prdata = rdata_r;

  // ---------------------------------------------------------------------------
  // Rate drop counters
  // ---------------------------------------------------------------------------
  assign rd_cnt[0] = access && !pwrite && hit_cnt0;
  assign rd_cnt[1] = access && !pwrite && hit_cnt1;
  assign rd_cnt[2] = access && !pwrite && hit_cnt2;

  // A drop that lands between the data capture and the clear survives the
  // read: it is seen as the difference to the captured value.
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      cnt_nxt[p] = cnt_r[p];
      if (rd_cnt[p]) begin
        cnt_nxt[p] = (cnt_r[p] != snap_r) ? CNT_ONE : CNT_ZERO;
        if (rate_drop[p]) begin
          cnt_nxt[p] = cnt_nxt[p] + CNT_ONE;
        end
      end else if (rate_drop[p] && cnt_r[p] != CNT_MAX) begin
        cnt_nxt[p] = cnt_r[p] + CNT_ONE;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Drop status records
  // ---------------------------------------------------------------------------
  // Reason and port codes pass through untouched; reserved codes are kept as
  // the detector reported them.
  assign rd_pend = access && !pwrite && hit_pend;
  assign clr_a   = rd_pend && rdata_r[PEND_A_VALID];
  assign clr_b   = rd_pend && rdata_r[PEND_B_VALID];

  always_comb begin
    rec_a_nxt = rec_a_r;
    rec_b_nxt = rec_b_r;
    rec_lost  = 1'b0;
    if (clr_a) begin
      rec_a_nxt = '0;
    end
    if (clr_b) begin
      rec_b_nxt = '0;
    end
    // Capture is independent of the mask, and a record freed by this cycle's
    // read is reused at once so the new drop is never lost.
    if (drop_evt.valid) begin
      if (!rec_a_nxt.valid) begin
        rec_a_nxt = drop_evt;
      end else if (!rec_b_nxt.valid) begin
        rec_b_nxt = drop_evt;
      end else begin
        rec_lost = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Mask, event status and enable
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [EVT_W-1:0] evt;
    evt      = '0;
    evt[NUM_PORTS-1:0] = rate_drop;
    evt[EVT_RECORD]    = drop_evt.valid;
    evt[EVT_LOST]      = rec_lost;
    mask_nxt = mask_r;
    en_nxt   = en_r;
    stat_nxt = stat_r;
    if (access && pwrite && hit_mask) begin
      mask_nxt = pwdata[MASK_BIT];
    end
    if (access && pwrite && hit_en) begin
      en_nxt = pwdata[EVT_W-1:0];
    end
    if (access && pwrite && hit_clr) begin
      stat_nxt = stat_r & ~pwdata[EVT_W-1:0];
    end
    stat_nxt = stat_nxt | evt;
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        cnt_r[p] <= CNT_ZERO;
      end
      snap_r  <= CNT_ZERO;
      mask_r  <= MASK_RST;
      rec_a_r <= '0;
      rec_b_r <= '0;
      stat_r  <= EVT_RST;
      en_r    <= EVT_RST;
      rdata_r <= 32'h0000_0000;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        cnt_r[p] <= cnt_nxt[p];
      end
      snap_r  <= snap_nxt;
      mask_r  <= mask_nxt;
      rec_a_r <= rec_a_nxt;
      rec_b_r <= rec_b_nxt;
      stat_r  <= stat_nxt;
      en_r    <= en_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // The mask is the master gate over every interrupt source of this block; the
  // event enables only pick sources beneath it, so a set mask silences them all.
  assign irq = !mask_r && ((rec_a_r.valid || rec_b_r.valid)
                           || |(stat_r & en_r));

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_cnt_increment: assert property (
    @(posedge pclk) disable iff (!presetn)
    rate_drop[0] && !rd_cnt[0] && cnt_r[0] != CNT_MAX |=> cnt_r[0] == $past(cnt_r[0]) + CNT_ONE)
    else $error("port 0 counter did not step on a drop");

  a_cnt_read_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && hit_cnt1 ##1 access && !rate_drop[1] && cnt_r[1] == snap_r
    |=> cnt_r[1] == CNT_ZERO)
    else $error("port 1 counter not cleared by read");

  a_cnt_saturate: assert property (
    @(posedge pclk) disable iff (!presetn)
    cnt_r[2] == CNT_MAX && !rd_cnt[2] |=> cnt_r[2] == CNT_MAX)
    else $error("port 2 counter wrapped");

  a_mask_blocks: assert property (
    @(posedge pclk) disable iff (!presetn)
    mask_r |-> !irq)
    else $error("interrupt raised while masked");

  a_mask_capture: assert property (
    @(posedge pclk) disable iff (!presetn)
    mask_r && drop_evt.valid && !rec_a_r.valid && !rd_pend |=> rec_a_r == $past(drop_evt))
    else $error("record not captured while masked");

  a_second_rec: assert property (
    @(posedge pclk) disable iff (!presetn)
    rec_a_r.valid && !rec_b_r.valid && drop_evt.valid && !rd_pend
    |=> rec_b_r == $past(drop_evt) && rec_a_r == $past(rec_a_r))
    else $error("second record not captured in B");

  a_pend_fields: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup && !pwrite && hit_pend |=> prdata[PEND_B_REASON+:4] == $past(rec_b_r.info.reason)
      && prdata[PEND_B_PORT+:2] == $past(rec_b_r.info.port)
      && prdata[PEND_B_VALID] == $past(rec_b_r.valid)
      && prdata[PEND_A_REASON+:4] == $past(rec_a_r.info.reason)
      && prdata[PEND_A_PORT+:2] == $past(rec_a_r.info.port)
      && prdata[PEND_A_VALID] == $past(rec_a_r.valid))
    else $error("pending register layout wrong");

  a_pend_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_pend && rdata_r[PEND_A_VALID] && rdata_r[PEND_B_VALID] && !drop_evt.valid
    |=> !rec_a_r.valid && !rec_b_r.valid)
    else $error("pending records not cleared by read");

  a_irq_raise: assert property (
    @(posedge pclk) disable iff (!presetn)
    !mask_r && (rec_a_r.valid || rec_b_r.valid) |-> irq)
    else $error("interrupt missing for a valid record");

endmodule // sdsi_regs

/* testbench/switch_drop_stats_irq_regs_tb_top.sv */
/*
  Self-checking bench of the drop statistics and interrupt register bank.
  Assumes the zero wait state APB slave of sdsi_regs with CNT_W set small.
*/
`timescale 1ns/1ps

module switch_drop_stats_irq_regs_tb_top;
  import sdsi_pkg::*;
  // A 4-bit counter reaches all ones in a few drops; the top bits must read zero.
  localparam int unsigned CW = 4;
  localparam logic [31:0] CMAX = 32'h0000_000F;

  logic                  pclk;
  logic                  presetn;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [ADDR_W-1:0]     paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic [NUM_PORTS-1:0]  rate_drop;
  sdsi_drop_rec_t        drop_evt;
  logic                  irq;
  int                    n_fail;
  int                    n_checks;
  logic [31:0]           rd;
  logic                  er;

  sdsi_regs #(.CNT_W(CW)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rate_drop(rate_drop), .drop_evt(drop_evt), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      give_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [13:0] idx, input logic [31:0] exp, input string msg);
    apb(1'b0, idx, 32'h0000_0000);
    chk(rd, exp, msg);
  endtask

  task automatic drops(input int p, input int k);
    repeat (k) begin
      @(posedge pclk);
      rate_drop <= 3'(1 << p);
      @(posedge pclk);
      rate_drop <= 3'h0;
    end
  endtask

  task automatic evt(input logic [3:0] r, input logic [1:0] p);
    @(posedge pclk);
    drop_evt <= '{valid: 1'b1, info: '{reason: r, port: p}};
    @(posedge pclk);
    drop_evt <= '0;
    @(negedge pclk);
  endtask

  function automatic logic [31:0] pend(logic [3:0] ra, logic [1:0] pa, logic [3:0] rb,
                                       logic [1:0] pb);
    return {18'h0, rb, pb, 1'b1, ra, pa, 1'b1};
  endfunction

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    rd_chk(IDX_IRQ_MASK, 32'h0000_0001, "mask reset");
    rd_chk(IDX_CNT_PORT0, 32'h0000_0000, "cnt0 reset");
    rd_chk(IDX_IRQ_PEND, 32'h0000_0000, "pend reset");
    chk({31'h0, irq}, 32'h0, "irq reset");
  endtask

  task automatic t_counters();
    logic [13:0] ix [3];
    ix = '{IDX_CNT_PORT0, IDX_CNT_PORT1, IDX_CNT_PORT2};
    for (int p = 0; p < 3; p++) drops(p, 3 + 2 * p);
    for (int p = 0; p < 3; p++) rd_chk(ix[p], 32'(3 + 2 * p), "count");
    for (int p = 0; p < 3; p++) rd_chk(ix[p], 32'h0, "cleared");
    drops(2, 18);
    rd_chk(IDX_CNT_PORT2, CMAX, "saturated");
    rd_chk(IDX_CNT_PORT2, 32'h0, "sat clear");
    apb(1'b1, IDX_CNT_PORT1, 32'h0000_0007);
    rd_chk(IDX_CNT_PORT1, 32'h0, "cnt write ignored");
  endtask

  task automatic t_records();
    logic [3:0] c [8];
    c = '{SDSI_RSN_BCAST_LEVEL, SDSI_RSN_RED, SDSI_RSN_NO_BUFFER, SDSI_RSN_NO_DESC,
          SDSI_RSN_NO_DEST, SDSI_RSN_RX_ERROR, SDSI_RSN_DROP_LEVEL, SDSI_RSN_YELLOW};
    for (int i = 0; i < 8; i += 2) begin
      evt(c[i], 2'(i % 3));
      evt(c[i + 1], 2'((i + 1) % 3));
      chk({31'h0, irq}, 32'h0, "masked irq");
      rd_chk(IDX_IRQ_PEND, pend(c[i], 2'(i % 3), c[i + 1], 2'((i + 1) % 3)), "pend");
      rd_chk(IDX_IRQ_PEND, 32'h0, "pend clear");
    end
  endtask

  task automatic t_irq();
    apb(1'b1, IDX_IRQ_MASK, 32'hFFFF_FFFE);
    rd_chk(IDX_IRQ_MASK, 32'h0, "mask write");
    chk({31'h0, irq}, 32'h0, "irq idle");
    evt(4'h1, 2'h2);
    chk({31'h0, irq}, 32'h1, "irq raised");
    rd_chk(IDX_IRQ_PEND, 32'h0000_000D, "pend A only");
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0, "irq dropped");
    apb(1'b1, IDX_IRQ_MASK, 32'hFFFF_FFFF);
    rd_chk(IDX_IRQ_MASK, 32'h1, "mask set");
  endtask

  task automatic t_events();
    // Earlier scenarios left sticky event bits behind; start from a clean slate.
    apb(1'b1, IDX_EVT_CLR, 32'h0000_001F);
    rd_chk(IDX_EVT_STAT, 32'h0, "evt pre clear");
    apb(1'b1, IDX_IRQ_MASK, 32'h0);
    apb(1'b1, IDX_EVT_EN, 32'h0000_0001);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0, "evt idle");
    drops(0, 1);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1, "evt irq");
    apb(1'b1, IDX_IRQ_MASK, 32'h1);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0, "evt masked");
    rd_chk(IDX_EVT_STAT, 32'h0000_0001, "evt stat");
    apb(1'b1, IDX_EVT_CLR, 32'h0000_001F);
    rd_chk(IDX_EVT_STAT, 32'h0, "evt cleared");
    chk({31'h0, irq}, 32'h0, "evt irq clear");
    evt(4'h2, 2'h0);
    evt(4'h6, 2'h1);
    evt(4'h9, 2'h2);
    rd_chk(IDX_EVT_STAT, 32'h0000_0018, "evt record lost");
    rd_chk(IDX_IRQ_PEND, pend(4'h2, 2'h0, 4'h6, 2'h1), "pend full");
    apb(1'b1, IDX_EVT_CLR, 32'h0000_001F);
    apb(1'b1, IDX_EVT_EN, 32'h0);
    rd_chk(14'h1C00, 32'h0, "unmapped data");
    chk({31'h0, er}, 32'h1, "unmapped error");
    apb(1'b0, IDX_EVT_CLR, 32'h0);
    chk({31'h0, er}, 32'h1, "clear reg read");
  endtask

  initial begin
    n_fail = 0;
    n_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    rate_drop = '0;
    drop_evt = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_counters();
    t_records();
    t_irq();
    t_events();
    give_verdict();
  end
endmodule // switch_drop_stats_irq_regs_tb_top
